// File: inc/scq_pkg.sv
// Package: register map, field layout and timing constants of the sounder command queue
package scq_pkg;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] SCQ_ADDR_QUEUE = 8'h00;
  localparam logic [7:0] SCQ_ADDR_ALERT = 8'h04;
  localparam logic [7:0] SCQ_ADDR_KEY = 8'h08;
  localparam logic [7:0] SCQ_ADDR_CONFIG = 8'h0c;
  localparam logic [7:0] SCQ_ADDR_STATUS = 8'h10;
  // ---------------------------------------------------------------
  // Field layout
  // ---------------------------------------------------------------
  localparam int SCQ_QUEUED_BIT = 0;
  localparam int SCQ_LEVEL_BIT = 1;
  localparam int SCQ_DUR_HI = 7;
  localparam int SCQ_DUR_LO = 5;
  localparam logic [2:0] SCQ_DUR_CONT = 3'h0;
  localparam logic [2:0] SCQ_DUR_1000 = 3'h7;
  localparam logic [5:0] SCQ_CTRL_ZERO = 6'h00;
  // Config bits
  localparam int SCQ_CFG_ALERT_EN = 0;
  localparam int SCQ_CFG_KEY_EN = 1;
  localparam int SCQ_CFG_GPO = 2;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SCQ_ALERT_RESET = 8'h01;
  localparam logic [7:0] SCQ_KEY_RESET = 8'h01;
  localparam logic [7:0] SCQ_QUEUE_RESET = 8'h00;
  localparam logic [2:0] SCQ_CFG_RESET = 3'h0;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SCQ_CLK_HZ = 20000000;
  localparam int SCQ_TICK_US = 1000;
  localparam int SCQ_TICK_CYCLES = SCQ_CLK_HZ / 1000000 * SCQ_TICK_US;
  localparam logic [3:0] SCQ_DUR_UNIT_MS = 4'h8;
  // Source of a command entering the queue
  typedef enum logic [1:0] {SCQ_SRC_NONE, SCQ_SRC_BUS, SCQ_SRC_ALERT, SCQ_SRC_KEY} scq_src_type;
endpackage : scq_pkg

// File: inc/scq_cmd_if.sv
// Interface: command hand-off from the queue to the tone player
`timescale 1ns/1ps
interface scq_cmd_if;
  logic start;
  logic [7:0] cmd;
  logic done;
  logic busy;
  modport queue (output start, output cmd, input done, input busy);
  modport player (input start, input cmd, output done, output busy);
endinterface : scq_cmd_if

// File: core/scq_player.sv
// Tone player: times the duration of the active command
`timescale 1ns/1ps
module scq_player #(
  parameter int TICK_CYCLES = scq_pkg::SCQ_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Command hand-off
  scq_cmd_if.player cmd_port
);
  import scq_pkg::*;

  // Elaboration check: the divider needs at least one cycle per tick
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("scq_player: TICK_CYCLES must be at least 1");
  end

  logic [31:0] tick_cnt;
  logic [11:0] ms_left;
  logic tick;

  // Millisecond tick divider
  always_ff @(posedge clk) begin
    if (rst || tick_cnt == 32'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 32'h1;
    end
  end
  assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));

  // Duration countdown; continuous code never ends on its own
  always_ff @(posedge clk) begin
    if (rst) begin
      ms_left <= '0;
      cmd_port.busy <= 1'b0;
      cmd_port.done <= 1'b0;
    end else begin
      cmd_port.done <= 1'b0;
      if (cmd_port.start) begin
        ms_left <= {cmd_port.cmd[SCQ_DUR_HI:SCQ_DUR_LO], 9'h000} + {5'h00, SCQ_DUR_UNIT_MS, 3'h0};
        cmd_port.busy <= 1'b1;
      end else if (cmd_port.busy && tick
                   && cmd_port.cmd[SCQ_DUR_HI:SCQ_DUR_LO] != SCQ_DUR_CONT) begin
        if (ms_left <= 12'h001) begin
          cmd_port.busy <= 1'b0;
          cmd_port.done <= 1'b1;
        end else begin
          ms_left <= ms_left - 12'h001;
        end
      end
    end
  end
endmodule : scq_player

// File: core/scq_top.sv
// Sounder command queue: APB registers, two-deep queue, alert and key triggers
`timescale 1ns/1ps
module scq_top #(
  parameter int TICK_CYCLES = scq_pkg::SCQ_TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and events
  input wire logic alert_in,
  input wire logic key_debounced,
  output logic sounder_out,
  output logic autoloop,
  output logic [7:0] tone_code,
  output logic tone_active
);
  import scq_pkg::*;

  // ---------------------------------------------------------------
  // Registers and state
  // ---------------------------------------------------------------
  logic [7:0] alert_tone_command;
  logic [7:0] key_tone_command;
  logic [2:0] config_bits;
  logic [7:0] playing;
  logic [7:0] waiting;
  logic queued;
  logic alert_s1, alert_s2, alert_s3;
  logic alert_fall;
  logic key_evt;
  logic wr_en, rd_en;
  logic [7:0] next_waiting;
  logic [7:0] trig_cmd;
  scq_src_type src;
  logic pop_waiting;

  // Elaboration check: the tone divider needs at least one cycle per tick
  if (TICK_CYCLES < 1) begin : g_tick_check
    $error("scq_top: TICK_CYCLES must be at least 1");
  end

  scq_cmd_if cmd_bus ();

  scq_player #(.TICK_CYCLES(TICK_CYCLES)) u_player (
    .clk(clk),
    .rst(rst),
    .cmd_port(cmd_bus.player)
  );

  // Substitutes bit 0 and the continuous duration of a trigger command
  function automatic logic [7:0] scq_fix_trigger(input logic [7:0] c);
    logic [7:0] r;
    r = {c[7:1], 1'b1};
    if (c[SCQ_DUR_HI:SCQ_DUR_LO] == SCQ_DUR_CONT) begin
      r[SCQ_DUR_HI:SCQ_DUR_LO] = SCQ_DUR_1000;
    end
    return r;
  endfunction : scq_fix_trigger

  // Control form: bits 7..2 all zero, no tone timing
  function automatic logic scq_is_ctrl(input logic [7:0] c);
    return c[7:2] == SCQ_CTRL_ZERO;
  endfunction : scq_is_ctrl

  // ---------------------------------------------------------------
  // Alert synchroniser and edge detect
  // ---------------------------------------------------------------
  // Third stage keeps the edge detector off the metastable flop
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_s1 <= 1'b1;
      alert_s2 <= 1'b1;
      alert_s3 <= 1'b1;
    end else begin
      alert_s1 <= alert_in;
      alert_s2 <= alert_s1;
      alert_s3 <= alert_s2;
    end
  end
  assign alert_fall = alert_s3 && !alert_s2;

  // Key debounce event comes from same-clock logic; edge it once
  logic key_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      key_q <= 1'b0;
    end else begin
      key_q <= key_debounced;
    end
  end
  assign key_evt = key_debounced && !key_q;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // Software registers
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_tone_command <= SCQ_ALERT_RESET;
      key_tone_command <= SCQ_KEY_RESET;
      config_bits <= SCQ_CFG_RESET;
    end else if (wr_en) begin
      if (paddr == SCQ_ADDR_ALERT) begin
        alert_tone_command <= {pwdata[7:1], 1'b1};
      end else if (paddr == SCQ_ADDR_KEY) begin
        key_tone_command <= {pwdata[7:1], 1'b1};
      end else if (paddr == SCQ_ADDR_CONFIG) begin
        config_bits <= pwdata[2:0];
      end
    end
  end

  // Read data is registered in the setup cycle, ready in access phase
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= '0;
      pslverr <= 1'b0;
      if (paddr == SCQ_ADDR_QUEUE) begin
        if (rd_en) prdata <= {24'h0, playing[7:1], queued};
      end else if (paddr == SCQ_ADDR_ALERT) begin
        if (rd_en) prdata <= {24'h0, alert_tone_command};
      end else if (paddr == SCQ_ADDR_KEY) begin
        if (rd_en) prdata <= {24'h0, key_tone_command};
      end else if (paddr == SCQ_ADDR_CONFIG) begin
        if (rd_en) prdata <= {29'h0, config_bits};
      end else if (paddr == SCQ_ADDR_STATUS) begin
        if (rd_en) prdata <= {30'h0, autoloop, cmd_bus.busy};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  // ---------------------------------------------------------------
  // Command source select
  // ---------------------------------------------------------------
  // Bus write wins a same-cycle clash; triggers then retry never
  always_comb begin
    src = SCQ_SRC_NONE;
    trig_cmd = pwdata[7:0];
    if (wr_en && paddr == SCQ_ADDR_QUEUE) begin
      src = SCQ_SRC_BUS;
    end else if (alert_fall && config_bits[SCQ_CFG_ALERT_EN]) begin
      src = SCQ_SRC_ALERT;
      trig_cmd = scq_fix_trigger(alert_tone_command);
    end else if (key_evt && config_bits[SCQ_CFG_KEY_EN]) begin
      src = SCQ_SRC_KEY;
      trig_cmd = scq_fix_trigger(key_tone_command);
    end
  end

  // ---------------------------------------------------------------
  // Two-deep queue
  // ---------------------------------------------------------------
  always_comb begin
    next_waiting = waiting;
    if (src == SCQ_SRC_BUS && trig_cmd[SCQ_QUEUED_BIT]) begin
      next_waiting = trig_cmd;
    end
  end

  // Waiting entry moves up when the player reports the end of a tone
  assign pop_waiting = cmd_bus.done && queued;

  // Queue update; a bus write in the cycle a tone ends must not swallow the pop,
  // otherwise the waiting entry would sit there with the player idle
  always_ff @(posedge clk) begin
    if (rst) begin
      playing <= SCQ_QUEUE_RESET;
      waiting <= SCQ_QUEUE_RESET;
      queued <= 1'b0;
      cmd_bus.start <= 1'b0;
    end else begin
      cmd_bus.start <= 1'b0;
      if (src == SCQ_SRC_BUS && !trig_cmd[SCQ_QUEUED_BIT]) begin
        playing <= trig_cmd;
        queued <= 1'b0;
        cmd_bus.start <= !scq_is_ctrl(trig_cmd);
      end else if (src == SCQ_SRC_BUS && scq_is_ctrl(trig_cmd)) begin
        // Control form leaves the queue alone, but a tone ending now still pops
        if (pop_waiting) begin
          playing <= waiting;
          queued <= 1'b0;
          cmd_bus.start <= 1'b1;
        end
      end else if (src == SCQ_SRC_BUS && !cmd_bus.busy && !queued) begin
        playing <= trig_cmd;
        cmd_bus.start <= 1'b1;
      end else if (src == SCQ_SRC_BUS) begin
        waiting <= next_waiting;
        queued <= 1'b1;
        if (pop_waiting) begin
          playing <= waiting;
          cmd_bus.start <= 1'b1;
        end
      end else if (src != SCQ_SRC_NONE) begin
        playing <= trig_cmd;
        cmd_bus.start <= 1'b1;
      end else if (pop_waiting) begin
        playing <= waiting;
        queued <= 1'b0;
        cmd_bus.start <= 1'b1;
      end
    end
  end
  assign cmd_bus.cmd = playing;

  // ---------------------------------------------------------------
  // Pin and mode outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      autoloop <= 1'b0;
      sounder_out <= 1'b0;
      tone_code <= '0;
      tone_active <= 1'b0;
    end else begin
      if (src == SCQ_SRC_BUS && trig_cmd[SCQ_QUEUED_BIT] && scq_is_ctrl(trig_cmd)) begin
        autoloop <= trig_cmd[SCQ_LEVEL_BIT];
      end
      if (config_bits[SCQ_CFG_GPO] && scq_is_ctrl(playing)) begin
        sounder_out <= playing[SCQ_LEVEL_BIT];
      end else begin
        sounder_out <= cmd_bus.busy;
      end
      tone_code <= {playing[7:1], 1'b0};
      tone_active <= cmd_bus.busy;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  alert_start_a: assert property (@(posedge clk) disable iff (rst)
    (alert_fall && config_bits[SCQ_CFG_ALERT_EN] && !(wr_en && paddr == SCQ_ADDR_QUEUE))
    |=> cmd_bus.start)
    else $error("alert edge did not start a tone");

  alert_copy_a: assert property (@(posedge clk) disable iff (rst)
    (src == SCQ_SRC_ALERT) |=> playing[4:1] == $past(alert_tone_command[4:1]))
    else $error("alert code not copied");

  alert_bit0_a: assert property (@(posedge clk) disable iff (rst)
    alert_tone_command[0] == 1'b1)
    else $error("alert bit 0 not one");

  cont_subst_a: assert property (@(posedge clk) disable iff (rst)
    (src == SCQ_SRC_ALERT && alert_tone_command[7:5] == SCQ_DUR_CONT)
    |=> playing[7:5] == SCQ_DUR_1000)
    else $error("continuous code not replaced");

  flush_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && paddr == SCQ_ADDR_QUEUE && !pwdata[0]) |=> !queued)
    else $error("queue not flushed");

  overwrite_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && paddr == SCQ_ADDR_QUEUE && pwdata[0] && queued && pwdata[7:2] != 6'h00)
    |=> queued && waiting == $past(pwdata[7:0]))
    else $error("waiting command not overwritten");

  gpo_level_a: assert property (@(posedge clk) disable iff (rst)
    (config_bits[SCQ_CFG_GPO] && playing[7:2] == 6'h00 && $stable(playing))
    |=> sounder_out == $past(playing[1]))
    else $error("gpo level wrong");

  sync_edge_a: assert property (@(posedge clk) disable iff (rst)
    alert_fall |=> !alert_fall)
    else $error("alert edge longer than one cycle");

  exec_now_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && paddr == SCQ_ADDR_QUEUE && !pwdata[0] && pwdata[7:2] != 6'h00)
    |=> cmd_bus.start && playing == $past(pwdata[7:0]))
    else $error("direct command not started");

  queue_pop_a: assert property (@(posedge clk) disable iff (rst)
    (pop_waiting && src == SCQ_SRC_NONE)
    |=> cmd_bus.start && !queued && playing == $past(waiting))
    else $error("waiting command not started");

  queue_flag_a: assert property (@(posedge clk) disable iff (rst)
    (rd_en && paddr == SCQ_ADDR_QUEUE) |=> prdata[0] == $past(queued))
    else $error("queue flag read wrong");

  autoloop_set_a: assert property (@(posedge clk) disable iff (rst)
    (wr_en && paddr == SCQ_ADDR_QUEUE && pwdata[0] && pwdata[7:2] == 6'h00)
    |=> autoloop == $past(pwdata[1]))
    else $error("autoloop not set");

  key_start_a: assert property (@(posedge clk) disable iff (rst)
    (src == SCQ_SRC_KEY)
    |=> cmd_bus.start && playing[4:1] == $past(key_tone_command[4:1]))
    else $error("key command not started");

  key_cont_a: assert property (@(posedge clk) disable iff (rst)
    (src == SCQ_SRC_KEY && key_tone_command[7:5] == SCQ_DUR_CONT)
    |=> playing[7:5] == SCQ_DUR_1000)
    else $error("continuous key code not replaced");

  code_out_a: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> tone_code == {$past(playing[7:1]), 1'b0})
    else $error("tone code does not follow command");

  busy_pin_a: assert property (@(posedge clk) disable iff (rst)
    !config_bits[SCQ_CFG_GPO] |=> sounder_out == $past(cmd_bus.busy))
    else $error("sounder pin does not follow tone");
endmodule : scq_top

// File: testbench/scq_host.sv
// Host model: APB master and alert pin driver for the sounder queue
`timescale 1ns/1ps
module scq_host (
  // Clock
  input wire logic clk,
  // APB master side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Alert pin, idles high
  output logic alert_in
);
  // Idle bus and released alert line at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    alert_in = 1'b1;
  end

  // One APB transfer; the wait has no bound of its own, the bench watchdog cuts a hang
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Alert pulse, held low long enough to pass the synchroniser
  task automatic alert_pulse();
    @(posedge clk);
    alert_in <= 1'b0;
    repeat (10) @(posedge clk);
    alert_in <= 1'b1;
  endtask : alert_pulse
endmodule : scq_host

// File: testbench/test_scq_top.sv
// Testbench: self-checking scenarios for the sounder command queue
`timescale 1ns/1ps
module test_scq_top;
  import scq_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, alert_in;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic key_debounced = 1'b0;
  logic sounder_out, autoloop, tone_active;
  logic [7:0] tone_code;
  int mismatches = 0;
  int comparisons = 0;

  // 20 MHz clock
  always #25 clk = ~clk;

  // Short tick keeps timed tone durations to at most 14592 cycles
  scq_top #(.TICK_CYCLES(4)) i_scq_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .alert_in(alert_in), .key_debounced(key_debounced),
    .sounder_out(sounder_out), .autoloop(autoloop), .tone_code(tone_code),
    .tone_active(tone_active));
  scq_host i_scq_host (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alert_in(alert_in));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e;
    i_scq_host.xfer(1'b1, a, {24'h0, d}, q, e);
  endtask : wr

  // Read one register and compare data and error flag
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    logic [31:0] q;
    logic e;
    i_scq_host.xfer(1'b0, a, 32'h0, q, e);
    chk(q, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(SCQ_ADDR_QUEUE, 32'h00, 1'b0);
    rd(SCQ_ADDR_ALERT, 32'h01, 1'b0);
    rd(8'h14, 32'h00, 1'b1);
  endtask : t_reset

  // Continuous alert code must become the 1000 ms code; disabled trigger must do nothing
  task automatic t_alert();
    wr(SCQ_ADDR_ALERT, 8'h0a);
    rd(SCQ_ADDR_ALERT, 32'h0b, 1'b0);
    i_scq_host.alert_pulse();
    rd(SCQ_ADDR_QUEUE, 32'h00, 1'b0);
    wr(SCQ_ADDR_CONFIG, 8'h01);
    i_scq_host.alert_pulse();
    rd(SCQ_ADDR_QUEUE, 32'hea, 1'b0);
    chk({24'h0, tone_code}, 32'hea);
  endtask : t_alert

  // Key trigger, then queueing, overwrite and immediate execution
  task automatic t_key_queue();
    int n;
    wr(SCQ_ADDR_KEY, 8'h04);
    wr(SCQ_ADDR_CONFIG, 8'h02);
    @(posedge clk);
    key_debounced <= 1'b1;
    repeat (8) @(posedge clk);
    key_debounced <= 1'b0;
    rd(SCQ_ADDR_QUEUE, 32'he4, 1'b0);
    wr(SCQ_ADDR_QUEUE, 8'h21);
    rd(SCQ_ADDR_QUEUE, 32'he5, 1'b0);
    wr(SCQ_ADDR_QUEUE, 8'h22);
    rd(SCQ_ADDR_QUEUE, 32'h22, 1'b0);
    chk({24'h0, tone_code}, 32'h22);
    chk({31'h0, tone_active}, 32'h1);
    rd(SCQ_ADDR_STATUS, 32'h01, 1'b0);
    wr(SCQ_ADDR_QUEUE, 8'h43);
    wr(SCQ_ADDR_QUEUE, 8'h65);
    rd(SCQ_ADDR_QUEUE, 32'h23, 1'b0);
    n = 0;
    while (tone_code !== 8'h64 && n < 6000) begin
      @(posedge clk);
      n++;
    end
    chk({24'h0, tone_code}, 32'h64);
    rd(SCQ_ADDR_QUEUE, 32'h64, 1'b0);
    n = 0;
    while (tone_active !== 1'b0 && n < 8000) begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, tone_active}, 32'h0);
    rd(SCQ_ADDR_STATUS, 32'h00, 1'b0);
  endtask : t_key_queue

  // Plain output level and autoloop control commands
  task automatic t_gpo();
    wr(SCQ_ADDR_CONFIG, 8'h04);
    wr(SCQ_ADDR_QUEUE, 8'h02);
    repeat (3) @(posedge clk);
    chk({31'h0, sounder_out}, 32'h1);
    wr(SCQ_ADDR_QUEUE, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, sounder_out}, 32'h0);
    wr(SCQ_ADDR_QUEUE, 8'h03);
    repeat (3) @(posedge clk);
    chk({31'h0, autoloop}, 32'h1);
    rd(SCQ_ADDR_STATUS, 32'h02, 1'b0);
    rd(SCQ_ADDR_QUEUE, 32'h00, 1'b0);
    wr(SCQ_ADDR_QUEUE, 8'h01);
    repeat (3) @(posedge clk);
    chk({31'h0, autoloop}, 32'h0);
  endtask : t_gpo

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_alert();
    t_key_queue();
    t_gpo();
    end_sim();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    end_sim();
  end
endmodule : test_scq_top
